// [ulm_line_modem_control.sv]
`timescale 1ns/100ps
module ulm_line_modem_control #(
   parameter int DEPTH = 64
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cs,
   input wire logic [2:0] addr,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic enh_func_en,
   input wire logic hw_flow_en,
   input wire logic half_duplex_dir_en,
   input wire logic sw_flow_en,
   input wire logic [1:0] trig_table_sel,
   input wire logic trig_dir_tx,
   input wire logic [7:0] programmable_trigger_level,
   input wire logic [1:0] tx_trig_sel,
   input wire logic [1:0] rx_trig_sel,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_par_bit,
   input wire logic rx_is_flow_char,
   input wire logic tx_halt,
   output logic txd,
   output logic rts_n,
   output logic dtr_n,
   output logic aux_output_two_n,
   output logic int_out,
   output logic int_oe,
   output logic loop_cts,
   output logic loop_dsr,
   output logic ring_indicator_n,
   output logic loop_cd,
   output logic tx_resume,
   output logic baud16_tick,
   output logic [7:0] rx_trig_level,
   output logic [7:0] tx_trig_level
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

   typedef struct packed {
      logic [7:0] line_format_control;
      logic [7:0] modem_output_control;
      logic [7:0] div_low;
      logic [7:0] divisor_high;
      logic [1:0] pre;
      logic [15:0] bcnt;
      logic tick;
      logic [DEPTH-1:0][8:0] q;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ovr;
      logic lsr_int;
      logic [7:0] rdata;
      logic [7:0] thr;
      logic thr_v;
      logic load;
      logic rts_n;
      logic dtr_n;
      logic aux2_n;
      logic int_out;
      logic int_oe;
      logic loop_cts;
      logic loop_dsr;
      logic loop_ri_n;
      logic loop_cd;
      logic resume;
      logic [7:0] rx_trig;
      logic [7:0] tx_trig;
   } ulm_state_t;

   ulm_state_t s_r;
   ulm_state_t s_nxt;
   logic tx_busy;
   logic wr;
   logic rd;
   logic div_sel;
   logic pre_tick;
   logic push;
   logic pop;
   logic perr;
   logic head_perr;
   logic [7:0] rx_masked;
   logic [7:0] lf;
   logic [7:0] mo;
   logic [15:0] divisor;

   ulm_tx_serializer u_tx (
      .clk(clk),
      .rstn(rstn),
      .tick16(s_r.tick),
      .load(s_r.load),
      .load_data(s_r.thr),
      .line_format(s_r.line_format_control),
      .txd(txd),
      .busy(tx_busy)
   );

   always_comb begin
      s_nxt = s_r;
      lf = s_r.line_format_control;
      mo = s_r.modem_output_control;
      wr = cs & wr_stb;
      rd = cs & rd_stb;
      div_sel = lf[ulm_pkg::LF_DIV_SEL];
      divisor = {s_r.divisor_high, s_r.div_low};

      // Baud reference: optional divide by four, then the divisor count.
      s_nxt.pre = s_r.pre + 2'h1;
      pre_tick = (enh_func_en & mo[ulm_pkg::MO_PRESCALE]) ?
                 (s_r.pre == ulm_pkg::PRESCALE_LAST) : 1'b1;
      s_nxt.tick = 1'b0;
      if (pre_tick && divisor != 16'h0000) begin
         if (s_r.bcnt >= divisor - 16'h0001) begin
            s_nxt.bcnt = 16'h0000;
            s_nxt.tick = 1'b1;
         end else begin
            s_nxt.bcnt = s_r.bcnt + 16'h0001;
         end
      end

      // Receive queue: masking to the word length keeps unused bits at zero.
      rx_masked = rx_data & (8'hFF >> (3'h3 - {1'b0, lf[1:0]}));
      perr = lf[ulm_pkg::LF_PAR_EN] &
             (rx_par_bit != ulm_pkg::parity_bit(rx_data, lf));
      s_nxt.resume = rx_valid & enh_func_en & mo[ulm_pkg::MO_XON_ANY];
      push = rx_valid & ~(sw_flow_en & rx_is_flow_char);
      pop = rd & ~div_sel & (addr == ulm_pkg::OFS_DATA) & (s_r.cnt != '0);
      if (push && s_r.cnt != FULL_CNT) begin
         s_nxt.q[s_r.wp] = {perr, rx_masked};
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, (push && s_r.cnt != FULL_CNT)} -
                  {{AW{1'b0}}, pop};
      head_perr = s_r.q[s_r.rp][8] & (s_r.cnt != '0);

      // Register writes.
      s_nxt.load = 1'b0;
      if (wr) begin
         case (addr)
            ulm_pkg::OFS_DATA: begin
               if (div_sel) begin
                  s_nxt.div_low = wdata;
               end else if (!s_r.thr_v) begin
                  // A write while the holding byte is still pending is dropped.
                  s_nxt.thr = wdata;
                  s_nxt.thr_v = 1'b1;
               end
            end
            ulm_pkg::OFS_DIV_HIGH: begin
               if (div_sel) s_nxt.divisor_high = wdata;
            end
            ulm_pkg::OFS_LINE_FORMAT: s_nxt.line_format_control = wdata;
            ulm_pkg::OFS_MODEM_OUT: s_nxt.modem_output_control = wdata;
            default: begin
            end
         endcase
      end
      if (s_r.thr_v && !tx_busy && !s_r.load && !tx_halt) begin
         s_nxt.load = 1'b1;
         s_nxt.thr_v = 1'b0;
      end

      // Register reads; the answer is registered one edge after the strobe.
      if (rd) begin
         case (addr)
            ulm_pkg::OFS_DATA: s_nxt.rdata = div_sel ? s_r.div_low :
                                             s_r.q[s_r.rp][7:0];
            ulm_pkg::OFS_DIV_HIGH: s_nxt.rdata = div_sel ? s_r.divisor_high : 8'h00;
            ulm_pkg::OFS_LINE_FORMAT: s_nxt.rdata = lf;
            ulm_pkg::OFS_MODEM_OUT: s_nxt.rdata = mo;
            ulm_pkg::OFS_LINE_FLAGS: s_nxt.rdata = {5'h00, head_perr, s_r.ovr,
                                                    (s_r.cnt != '0)};
            default: s_nxt.rdata = 8'h00;
         endcase
      end

      // Overrun and line-status interrupt: a new event beats the read that clears.
      if (rd && addr == ulm_pkg::OFS_LINE_FLAGS) begin
         s_nxt.ovr = 1'b0;
         s_nxt.lsr_int = 1'b0;
      end
      if (push && s_r.cnt == FULL_CNT) begin
         s_nxt.ovr = 1'b1;
         s_nxt.lsr_int = 1'b1;
      end
      if (push && s_r.cnt != FULL_CNT && perr) begin
         s_nxt.lsr_int = 1'b1;
      end

      // Modem outputs; in loopback the pins go inactive and the bits loop back.
      if (mo[ulm_pkg::MO_LOOP]) begin
         s_nxt.dtr_n = 1'b1;
         s_nxt.rts_n = 1'b1;
         s_nxt.aux2_n = 1'b1;
      end else begin
         s_nxt.dtr_n = ~mo[ulm_pkg::MO_TERM_READY];
         s_nxt.aux2_n = ~mo[ulm_pkg::MO_AUX_INT];
         if (half_duplex_dir_en) begin
            // Driver direction follows the transmitter, holding byte included.
            s_nxt.rts_n = ~(tx_busy | s_r.thr_v | s_r.load);
         end else if (hw_flow_en) begin
            s_nxt.rts_n = ~mo[ulm_pkg::MO_REQ_SEND] |
                          (s_r.cnt >= {1'b0, s_r.rx_trig});
         end else begin
            s_nxt.rts_n = ~mo[ulm_pkg::MO_REQ_SEND];
         end
      end
      s_nxt.loop_dsr = mo[ulm_pkg::MO_LOOP] & mo[ulm_pkg::MO_TERM_READY];
      s_nxt.loop_cts = mo[ulm_pkg::MO_LOOP] & mo[ulm_pkg::MO_REQ_SEND];
      s_nxt.loop_ri_n = ~(mo[ulm_pkg::MO_LOOP] & mo[ulm_pkg::MO_RING]);
      s_nxt.loop_cd = mo[ulm_pkg::MO_LOOP] & mo[ulm_pkg::MO_AUX_INT];
      // The alternate host bus needs the enable kept low by software.
      s_nxt.int_oe = mo[ulm_pkg::MO_AUX_INT];
      s_nxt.int_out = s_r.lsr_int;

      // Trigger levels; table D takes the programmable value for one direction.
      if (trig_table_sel == ulm_pkg::TRIG_TAB_D) begin
         if (trig_dir_tx) s_nxt.tx_trig = programmable_trigger_level;
         else s_nxt.rx_trig = programmable_trigger_level;
      end else begin
         s_nxt.tx_trig = ulm_pkg::trig_level(trig_table_sel, tx_trig_sel, 1'b1);
         s_nxt.rx_trig = ulm_pkg::trig_level(trig_table_sel, rx_trig_sel, 1'b0);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.line_format_control <= ulm_pkg::LINE_FORMAT_RST;
         s_r.modem_output_control <= ulm_pkg::MODEM_OUT_RST;
         s_r.div_low <= ulm_pkg::DIV_LOW_RST;
         s_r.divisor_high <= ulm_pkg::DIV_HIGH_RST;
         s_r.rts_n <= 1'b1;
         s_r.dtr_n <= 1'b1;
         s_r.aux2_n <= 1'b1;
         s_r.loop_ri_n <= 1'b1;
         s_r.rx_trig <= 8'h01;
         s_r.tx_trig <= 8'h01;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign rts_n = s_r.rts_n;
   assign dtr_n = s_r.dtr_n;
   assign aux_output_two_n = s_r.aux2_n;
   assign int_out = s_r.int_out;
   assign int_oe = s_r.int_oe;
   assign loop_cts = s_r.loop_cts;
   assign loop_dsr = s_r.loop_dsr;
   assign ring_indicator_n = s_r.loop_ri_n;
   assign loop_cd = s_r.loop_cd;
   assign tx_resume = s_r.resume;
   assign baud16_tick = s_r.tick;
   assign rx_trig_level = s_r.rx_trig;
   assign tx_trig_level = s_r.tx_trig;
endmodule : ulm_line_modem_control

// [ulm_pkg.sv]
package ulm_pkg;
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
   localparam logic [2:0] OFS_LINE_FORMAT = 3'h3;
   localparam logic [2:0] OFS_MODEM_OUT = 3'h4;
   localparam logic [2:0] OFS_LINE_FLAGS = 3'h5;
   localparam logic [7:0] LINE_FORMAT_RST = 8'h00;
   localparam logic [7:0] MODEM_OUT_RST = 8'h00;
   localparam logic [7:0] DIV_LOW_RST = 8'h01;
   localparam logic [7:0] DIV_HIGH_RST = 8'h00;
   localparam int LF_WLEN_LO = 0;
   localparam int LF_STOP = 2;
   localparam int LF_PAR_EN = 3;
   localparam int LF_PAR_EVEN = 4;
   localparam int LF_PAR_FORCE = 5;
   localparam int LF_BREAK = 6;
   localparam int LF_DIV_SEL = 7;
   localparam int MO_TERM_READY = 0;
   localparam int MO_REQ_SEND = 1;
   localparam int MO_RING = 2;
   localparam int MO_AUX_INT = 3;
   localparam int MO_LOOP = 4;
   localparam int MO_XON_ANY = 5;
   localparam int MO_PRESCALE = 7;
   localparam int LS_READY = 0;
   localparam int LS_OVERRUN = 1;
   localparam int LS_PARITY = 2;
   localparam logic [5:0] TICKS_ONE_STOP = 6'd16;
   localparam logic [5:0] TICKS_HALF_MORE = 6'd24;
   localparam logic [5:0] TICKS_TWO_STOP = 6'd32;
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   localparam logic [1:0] TRIG_TAB_A = 2'h0;
   localparam logic [1:0] TRIG_TAB_B = 2'h1;
   localparam logic [1:0] TRIG_TAB_C = 2'h2;
   localparam logic [1:0] TRIG_TAB_D = 2'h3;

   function automatic logic [2:0] last_bit(input logic [1:0] wl);
      last_bit = {1'b1, wl} ;
   endfunction : last_bit

   function automatic logic parity_bit(input logic [7:0] d, input logic [7:0] lf);
      logic [7:0] m;
      m = d & (8'hFF >> (3'h3 - {1'b0, lf[1:0]}));
      if (lf[LF_PAR_FORCE]) begin
         parity_bit = ~lf[LF_PAR_EVEN];
      end else begin
         parity_bit = lf[LF_PAR_EVEN] ? (^m) : ~(^m);
      end
   endfunction : parity_bit

   // Fixed trigger levels; table D is handled by the caller.
   function automatic logic [7:0] trig_level(input logic [1:0] tab, input logic [1:0] sel,
                                             input logic is_tx);
      logic [7:0] v;
      v = 8'h01;
      case (tab)
         TRIG_TAB_B: begin
            if (is_tx) v = (sel == 2'h0) ? 8'h10 : (sel == 2'h1) ? 8'h08 :
                           (sel == 2'h2) ? 8'h18 : 8'h1E;
            else v = (sel == 2'h0) ? 8'h08 : (sel == 2'h1) ? 8'h10 :
                     (sel == 2'h2) ? 8'h18 : 8'h1C;
         end
         TRIG_TAB_C: begin
            if (is_tx) v = (sel == 2'h0) ? 8'h08 : (sel == 2'h1) ? 8'h10 :
                           (sel == 2'h2) ? 8'h20 : 8'h38;
            else v = (sel == 2'h0) ? 8'h08 : (sel == 2'h1) ? 8'h10 :
                     (sel == 2'h2) ? 8'h38 : 8'h3C;
         end
         default: begin
            if (!is_tx) v = (sel == 2'h0) ? 8'h01 : (sel == 2'h1) ? 8'h04 :
                            (sel == 2'h2) ? 8'h08 : 8'h0E;
         end
      endcase
      trig_level = v;
   endfunction : trig_level
endpackage : ulm_pkg

// [ulm_tx_serializer.sv]
`timescale 1ns/100ps
module ulm_tx_serializer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tick16,
   input wire logic load,
   input wire logic [7:0] load_data,
   input wire logic [7:0] line_format,
   output logic txd,
   output logic busy
);
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ulm_tx_st_t;
   typedef struct packed {
      ulm_tx_st_t st;
      logic [5:0] tcnt;
      logic [2:0] bidx;
      logic [7:0] sh;
      logic par;
      logic txd;
      logic busy;
   } ulm_tx_state_t;

   ulm_tx_state_t s_r;
   ulm_tx_state_t s_nxt;
   logic line;
   logic [5:0] stop_ticks;

   always_comb begin
      s_nxt = s_r;
      line = 1'b1;
      stop_ticks = !line_format[ulm_pkg::LF_STOP] ? ulm_pkg::TICKS_ONE_STOP :
                   (line_format[1:0] == 2'h0) ? ulm_pkg::TICKS_HALF_MORE : ulm_pkg::TICKS_TWO_STOP;
      case (s_r.st)
         ST_IDLE: begin
            if (load) begin
               s_nxt.st = ST_START;
               s_nxt.sh = load_data;
               s_nxt.par = ulm_pkg::parity_bit(load_data, line_format);
               s_nxt.tcnt = 6'd0;
               s_nxt.bidx = 3'd0;
            end
         end
         ST_START: begin
            line = 1'b0;
            if (tick16) begin
               s_nxt.tcnt = s_r.tcnt + 6'd1;
               if (s_r.tcnt[3:0] == ulm_pkg::TICK_LAST) begin
                  s_nxt.st = ST_DATA;
                  s_nxt.tcnt = 6'd0;
               end
            end
         end
         ST_DATA: begin
            line = s_r.sh[0];
            if (tick16) begin
               s_nxt.tcnt = s_r.tcnt + 6'd1;
               if (s_r.tcnt[3:0] == ulm_pkg::TICK_LAST) begin
                  s_nxt.tcnt = 6'd0;
                  s_nxt.sh = {1'b0, s_r.sh[7:1]};
                  s_nxt.bidx = s_r.bidx + 3'd1;
                  if (s_r.bidx == ulm_pkg::last_bit(line_format[1:0])) begin
                     s_nxt.st = line_format[ulm_pkg::LF_PAR_EN] ? ST_PAR : ST_STOP;
                  end
               end
            end
         end
         ST_PAR: begin
            line = s_r.par;
            if (tick16) begin
               s_nxt.tcnt = s_r.tcnt + 6'd1;
               if (s_r.tcnt[3:0] == ulm_pkg::TICK_LAST) begin
                  s_nxt.st = ST_STOP;
                  s_nxt.tcnt = 6'd0;
               end
            end
         end
         ST_STOP: begin
            if (tick16) begin
               s_nxt.tcnt = s_r.tcnt + 6'd1;
               if (s_r.tcnt == stop_ticks - 6'd1) begin
                  s_nxt.st = ST_IDLE;
               end
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
      // Break overrides the frame but the frame keeps its timing underneath.
      s_nxt.txd = line_format[ulm_pkg::LF_BREAK] ? 1'b0 : line;
      s_nxt.busy = (s_nxt.st != ST_IDLE);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '{st: ST_IDLE, tcnt: 6'd0, bidx: 3'd0, sh: 8'h00, par: 1'b0,
                  txd: 1'b1, busy: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign txd = s_r.txd;
   assign busy = s_r.busy;
endmodule : ulm_tx_serializer

// [ulm_line_modem_control_asserts.sv]
`timescale 1ns/100ps
module ulm_line_modem_control_asserts #(
   parameter int DEPTH = 64
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cs,
   input wire logic [2:0] addr,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic enh_func_en,
   input wire logic hw_flow_en,
   input wire logic half_duplex_dir_en,
   input wire logic sw_flow_en,
   input wire logic [1:0] trig_table_sel,
   input wire logic [1:0] tx_trig_sel,
   input wire logic rx_valid,
   input wire logic rx_is_flow_char,
   input wire logic txd,
   input wire logic rts_n,
   input wire logic dtr_n,
   input wire logic aux_output_two_n,
   input wire logic int_out,
   input wire logic int_oe,
   input wire logic loop_cts,
   input wire logic loop_dsr,
   input wire logic ring_indicator_n,
   input wire logic loop_cd,
   input wire logic tx_resume,
   input wire logic [7:0] tx_trig_level
);
   logic [7:0] lcr_r, mcr_r, cnt_r;
   logic [1:0] age_r, ctl_r;
   logic push, pop;
   // Modem pins, loop bits, int enable and break are judged only once settled.
   assign push = rx_valid && !(sw_flow_en && rx_is_flow_char) && cnt_r < DEPTH;
   assign pop = cs && rd_stb && addr == ulm_pkg::OFS_DATA && !lcr_r[7] && cnt_r != 8'h00;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lcr_r <= 8'h00;
         mcr_r <= 8'h00;
         cnt_r <= 8'h00;
         age_r <= 2'h0;
         ctl_r <= 2'h0;
      end else begin
         ctl_r <= {hw_flow_en, half_duplex_dir_en};
         if (cs && wr_stb && addr == ulm_pkg::OFS_LINE_FORMAT) lcr_r <= wdata;
         if (cs && wr_stb && addr == ulm_pkg::OFS_MODEM_OUT) mcr_r <= wdata;
         if ((cs && wr_stb) || ctl_r != {hw_flow_en, half_duplex_dir_en}) age_r <= 2'h0;
         else if (age_r != 2'h3) age_r <= age_r + 2'h1;
         cnt_r <= cnt_r + 8'(push) - 8'(pop);
      end
   end
   function automatic logic [7:0] trig_c(input logic [1:0] s);
      trig_c = (s == 2'h0) ? 8'h08 : (s == 2'h1) ? 8'h10 : (s == 2'h2) ? 8'h20 : 8'h38;
   endfunction : trig_c
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_settled; age_r >= 2'h2; endsequence
   sequence s_flags_rd; cs && rd_stb && addr == ulm_pkg::OFS_LINE_FLAGS; endsequence
   property p_dtr; s_settled |-> dtr_n == (mcr_r[4] | ~mcr_r[0]) && loop_dsr == (mcr_r[4] & mcr_r[0]); endproperty
   property p_rts;
      s_settled ##0 (!hw_flow_en && !half_duplex_dir_en)
         |-> rts_n == (mcr_r[4] | ~mcr_r[1]) && loop_cts == (mcr_r[4] & mcr_r[1]);
   endproperty
   property p_ring;
      s_settled |-> ring_indicator_n == ~(mcr_r[4] & mcr_r[2]) && loop_cd == (mcr_r[4] & mcr_r[3]);
   endproperty
   property p_aux; s_settled |-> int_oe == mcr_r[3] && aux_output_two_n == (mcr_r[4] | ~mcr_r[3]); endproperty
   property p_brk; s_settled ##0 lcr_r[6] |-> !txd; endproperty
   property p_trig_tx;
      $past(trig_table_sel) == ulm_pkg::TRIG_TAB_C && trig_table_sel == ulm_pkg::TRIG_TAB_C
         && $stable(tx_trig_sel) |-> tx_trig_level == trig_c(tx_trig_sel);
   endproperty
   property p_ready; s_flags_rd |=> rdata[ulm_pkg::LS_READY] == ($past(cnt_r) != 8'h00); endproperty
   property p_ovr; rx_valid && !push && !pop && !(sw_flow_en && rx_is_flow_char) |-> ##2 int_out; endproperty
   property p_intclr; s_flags_rd ##0 !rx_valid |-> ##2 !int_out; endproperty
   property p_resume; rx_valid && enh_func_en && mcr_r[ulm_pkg::MO_XON_ANY] |=> tx_resume; endproperty
   a_dtr: assert property (p_dtr) else $error("dtr state wrong");
   a_rts: assert property (p_rts) else $error("rts state wrong");
   a_ring: assert property (p_ring) else $error("ring or loop state wrong");
   a_aux: assert property (p_aux) else $error("aux or int enable wrong");
   a_brk: assert property (p_brk) else $error("break not held");
   a_trig_tx: assert property (p_trig_tx) else $error("tx trigger wrong");
   a_ready: assert property (p_ready) else $error("ready flag wrong");
   a_ovr: assert property (p_ovr) else $error("overrun not flagged");
   a_intclr: assert property (p_intclr) else $error("status int not cleared");
   a_resume: assert property (p_resume) else $error("no resume pulse");
endmodule : ulm_line_modem_control_asserts
bind ulm_line_modem_control ulm_line_modem_control_asserts #(.DEPTH(DEPTH)) u_asserts (.clk, .rstn,
   .cs, .addr, .wr_stb, .rd_stb, .wdata, .rdata, .enh_func_en, .hw_flow_en, .half_duplex_dir_en,
   .sw_flow_en, .trig_table_sel, .tx_trig_sel, .rx_valid, .rx_is_flow_char, .txd, .rts_n, .dtr_n,
   .aux_output_two_n, .int_out, .int_oe, .loop_cts, .loop_dsr, .ring_indicator_n, .loop_cd,
   .tx_resume, .tx_trig_level);

// [ulm_host_model.sv]
`timescale 1ns/100ps
module ulm_host_model #(
   parameter bit ALT_BUS = 1'b0
) (
   input wire logic clk,
   output logic cs,
   output logic [2:0] addr,
   output logic wr_stb,
   output logic rd_stb,
   output logic [7:0] wdata
);
   logic [7:0] exp_q [$];
   initial begin
      cs = 1'b0;
      addr = 3'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      wdata = 8'h00;
   end
   // A released bus shows inverted leftovers; a read leaves wdata as it was.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      cs = 1'b1;
      addr = a;
      wdata = (ALT_BUS && a == ulm_pkg::OFS_MODEM_OUT) ? (d & 8'hF7) : d;
      wr_stb = 1'b1;
      @(negedge clk);
      cs = 1'b0;
      wr_stb = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(negedge clk);
      cs = 1'b1;
      addr = a;
      rd_stb = 1'b1;
      exp_q.push_back(e);
      @(negedge clk);
      cs = 1'b0;
      rd_stb = 1'b0;
      addr = ~a;
   endtask : rd
endmodule : ulm_host_model

// [ulm_line_modem_control_test.sv]
`timescale 1ns/100ps
module ulm_line_modem_control_test;
   logic clk, rstn, cs, wr_stb, rd_stb, enh_func_en, hw_flow_en, half_duplex_dir_en, sw_flow_en;
   logic trig_dir_tx, rx_valid, rx_par_bit, rx_is_flow_char, tx_halt, txd, rts_n, dtr_n;
   logic aux_output_two_n, int_out, int_oe, loop_cts, loop_dsr, ring_indicator_n, loop_cd;
   logic tx_resume, baud16_tick, rd_pend;
   logic [2:0] addr;
   logic [1:0] trig_table_sel, tx_trig_sel, rx_trig_sel;
   logic [7:0] wdata, rdata, programmable_trigger_level, rx_data, rx_trig_level, tx_trig_level, v;
   logic [7:0] tx_tab [4] = '{8'h08, 8'h10, 8'h20, 8'h38};
   logic [7:0] rx_tab [4] = '{8'h08, 8'h10, 8'h38, 8'h3C};
   logic [7:0] fmt [6] = '{8'h00, 8'h0D, 8'h1A, 8'h2F, 8'h3B, 8'h04};
   logic [7:0] dq [5];
   int mismatches, tests_run;
   ulm_line_modem_control #(.DEPTH(4)) dut (.clk, .rstn, .cs, .addr, .wr_stb, .rd_stb, .wdata,
      .rdata, .enh_func_en, .hw_flow_en, .half_duplex_dir_en, .sw_flow_en, .trig_table_sel,
      .trig_dir_tx, .programmable_trigger_level, .tx_trig_sel, .rx_trig_sel, .rx_valid, .rx_data,
      .rx_par_bit, .rx_is_flow_char, .tx_halt, .txd, .rts_n, .dtr_n, .aux_output_two_n, .int_out,
      .int_oe, .loop_cts, .loop_dsr, .ring_indicator_n, .loop_cd, .tx_resume, .baud16_tick,
      .rx_trig_level, .tx_trig_level);
   ulm_host_model host (.clk, .cs, .addr, .wr_stb, .rd_stb, .wdata);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
      tests_run++;
      if (g !== x) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic test_done;
      if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   always @(posedge clk) rd_pend <= cs && rd_stb;
   always @(negedge clk) begin
      if (rd_pend === 1'b1 && host.exp_q.size() > 0) chk("rdata", host.exp_q.pop_front(), rdata);
   end
   task automatic tick(input int k);
      repeat (k) do @(negedge clk); while (baud16_tick !== 1'b1);
   endtask : tick
   task automatic gap(input logic [7:0] x);
      int n = 0;
      tick(2);
      do begin @(negedge clk); n++; end while (baud16_tick !== 1'b1 && n < 20);
      chk("tick gap", x, 8'(n));
   endtask : gap
   task automatic rx(input logic [7:0] d, input logic p);
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = d;
      rx_par_bit = p;
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~d;
   endtask : rx
   task automatic frame(input logic [7:0] f, input logic [7:0] d);
      int nb, n = 0, s;
      logic [7:0] m;
      nb = 5 + f[1:0];
      m = d & (8'hFF >> (8 - nb));
      s = f[2] ? ((nb == 5) ? 24 : 32) : 16;
      host.wr(ulm_pkg::OFS_LINE_FORMAT, f);
      host.wr(ulm_pkg::OFS_DATA, d);
      host.wr(ulm_pkg::OFS_DATA, ~d);
      while (txd !== 1'b0 && n < 200) begin @(negedge clk); n++; end
      tick(8);
      chk("start", 8'h00, 8'(txd));
      chk("rts_n", 8'h00, 8'(rts_n));
      for (int i = 0; i < nb; i++) begin tick(16); chk("data", 8'(d[i]), 8'(txd)); end
      if (f[3]) begin tick(16); chk("par", 8'(f[5] ? !f[4] : !(f[4] ^ ^m)), 8'(txd)); end
      tick(16);
      chk("stop", 8'h01, 8'(txd));
      n = 0;
      while (txd === 1'b1 && n < 64) begin tick(1); n++; end
      chk("stop len", 8'(s - 6), 8'(n));
      tick(192);
   endtask : frame
   initial begin
      {rstn, enh_func_en, hw_flow_en, half_duplex_dir_en, sw_flow_en, trig_dir_tx} = 6'h00;
      {rx_valid, rx_par_bit, rx_is_flow_char, tx_halt} = 4'h0;
      {trig_table_sel, tx_trig_sel, rx_trig_sel} = 6'h00;
      programmable_trigger_level = 8'h00;
      rx_data = 8'h00;
      mismatches = 0;
      tests_run = 0;
      v = 8'($urandom(41));
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      chk("txd idle", 8'h01, 8'(txd));
      host.rd(ulm_pkg::OFS_LINE_FORMAT, ulm_pkg::LINE_FORMAT_RST);
      host.rd(ulm_pkg::OFS_MODEM_OUT, ulm_pkg::MODEM_OUT_RST);
      host.rd(ulm_pkg::OFS_LINE_FLAGS, 8'h00);
      trig_table_sel = ulm_pkg::TRIG_TAB_C;
      for (int i = 0; i < 4; i++) begin
         {tx_trig_sel, rx_trig_sel} = {2'(i), 2'(i)};
         repeat (3) @(negedge clk);
         chk("tx trig", tx_tab[i], tx_trig_level);
         chk("rx trig", rx_tab[i], rx_trig_level);
      end
      {trig_table_sel, trig_dir_tx, programmable_trigger_level} = {ulm_pkg::TRIG_TAB_D, 1'b1, v};
      repeat (3) @(negedge clk);
      chk("tx trig", v, tx_trig_level);
      {trig_table_sel, tx_trig_sel, rx_trig_sel} = 6'h00;
      for (int i = 0; i < 6; i++) begin
         v = 8'($urandom()) & 8'h3F;
         host.wr(ulm_pkg::OFS_LINE_FORMAT, v);
         host.rd(ulm_pkg::OFS_LINE_FORMAT, v);
         v = (i == 0) ? 8'h1F : 8'($urandom());
         host.wr(ulm_pkg::OFS_MODEM_OUT, v);
         host.rd(ulm_pkg::OFS_MODEM_OUT, v);
         repeat (3) @(negedge clk);
      end
      host.wr(ulm_pkg::OFS_MODEM_OUT, 8'h00);
      host.wr(ulm_pkg::OFS_LINE_FORMAT, 8'h80);
      host.wr(ulm_pkg::OFS_DIV_HIGH, 8'hA5);
      host.rd(ulm_pkg::OFS_DIV_HIGH, 8'hA5);
      host.wr(ulm_pkg::OFS_DIV_HIGH, 8'h00);
      host.rd(ulm_pkg::OFS_DATA, ulm_pkg::DIV_LOW_RST);
      host.wr(ulm_pkg::OFS_LINE_FORMAT, 8'h00);
      host.rd(ulm_pkg::OFS_DIV_HIGH, 8'h00);
      host.wr(3'h7, 8'hFF);
      host.rd(3'h7, 8'h00);
      half_duplex_dir_en = 1'b1;
      foreach (fmt[k]) frame(fmt[k], 8'($urandom()));
      half_duplex_dir_en = 1'b0;
      repeat (3) @(negedge clk);
      chk("rts_n", 8'h01, 8'(rts_n));
      host.wr(ulm_pkg::OFS_LINE_FORMAT, 8'h40);
      repeat (20) @(negedge clk);
      chk("break", 8'h00, 8'(txd));
      host.wr(ulm_pkg::OFS_LINE_FORMAT, 8'h00);
      repeat (3) @(negedge clk);
      chk("break off", 8'h01, 8'(txd));
      enh_func_en = 1'b1;
      host.wr(ulm_pkg::OFS_MODEM_OUT, 8'h80);
      gap(8'h04);
      host.wr(ulm_pkg::OFS_MODEM_OUT, 8'h20);
      gap(8'h01);
      rx(8'h11, 1'b0);
      chk("tx_resume", 8'h01, 8'(tx_resume));
      {sw_flow_en, rx_is_flow_char} = 2'h3;
      rx(8'h13, 1'b0);
      {sw_flow_en, rx_is_flow_char} = 2'h0;
      host.rd(ulm_pkg::OFS_LINE_FLAGS, 8'h01);
      host.rd(ulm_pkg::OFS_DATA, 8'h11);
      host.rd(ulm_pkg::OFS_LINE_FLAGS, 8'h00);
      enh_func_en = 1'b0;
      hw_flow_en = 1'b1;
      host.wr(ulm_pkg::OFS_MODEM_OUT, 8'h02);
      rx(8'h05, 1'b0);
      repeat (3) @(negedge clk);
      chk("rts_n flow", 8'h01, 8'(rts_n));
      host.rd(ulm_pkg::OFS_DATA, 8'h05);
      repeat (3) @(negedge clk);
      chk("rts_n", 8'h00, 8'(rts_n));
      hw_flow_en = 1'b0;
      host.wr(ulm_pkg::OFS_LINE_FORMAT, 8'h1B);
      for (int i = 0; i < 5; i++) begin
         dq[i] = 8'($urandom());
         rx(dq[i], (i == 0) ? ~^dq[i] : ^dq[i]);
      end
      repeat (2) @(negedge clk);
      chk("int_out", 8'h01, 8'(int_out));
      host.rd(ulm_pkg::OFS_LINE_FLAGS, 8'h07);
      host.rd(ulm_pkg::OFS_LINE_FLAGS, 8'h05);
      repeat (3) @(negedge clk);
      chk("int_out", 8'h00, 8'(int_out));
      host.rd(ulm_pkg::OFS_DATA, dq[0]);
      host.rd(ulm_pkg::OFS_LINE_FLAGS, 8'h01);
      for (int i = 1; i < 4; i++) host.rd(ulm_pkg::OFS_DATA, dq[i]);
      host.rd(ulm_pkg::OFS_LINE_FLAGS, 8'h00);
      repeat (3) @(negedge clk);
      test_done();
   end
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      test_done();
   end
endmodule : ulm_line_modem_control_test
